// ===== core/uvst_defs.svh
// Constants for the undervoltage stage timing block
`ifndef UVST_DEFS_SVH
`define UVST_DEFS_SVH
// Register byte offsets
`define UVST_CTRL_OFS      12'h000
`define UVST_DELAY_OFS     12'h004
`define UVST_DIAL_OFS      12'h008
`define UVST_EXPO_OFS      12'h00C
`define UVST_RELEASE_OFS   12'h010
`define UVST_BLKLVL_OFS    12'h014
`define UVST_STATUS_OFS    12'h018
`define UVST_REMAIN_OFS    12'h01C
`define UVST_RATIO_AB_OFS  12'h020
`define UVST_RATIO_C_OFS   12'h024
`define UVST_EXPECT_OFS    12'h028
// Control fields
`define UVST_CTRL_INV_BIT      0
`define UVST_CTRL_DREL_BIT     1
`define UVST_CTRL_TRST_BIT     2
`define UVST_CTRL_CONT_BIT     3
`define UVST_CTRL_FEN_BIT      4
`define UVST_CTRL_FSEL_LSB     5
`define UVST_CTRL_RESET    32'h0000_0006
// Reset values, in 5 ms ticks or 0.01 units
`define UVST_DELAY_RESET   32'h0000_0008
`define UVST_DIAL_RESET    32'h0000_0005
`define UVST_EXPO_RESET    32'h0000_0064
`define UVST_RELEASE_RESET 32'h0000_000C
`define UVST_BLKLVL_RESET  32'h0000_000A
// Timing
`define UVST_TICK_NS       5000000
`define UVST_CLK_NS        100
`define UVST_TICK_CYCLES   (`UVST_TICK_NS / `UVST_CLK_NS)
// Pickup drop-out ratio in 0.01 units: 103 %
`define UVST_HYST_PCT      16'h0067
`define UVST_ONE_RATIO     16'h0064
`endif

// ===== core/uvst_inverse_time.sv
// Inverse-time operate delay calculator
`timescale 1ns/1ps
`default_nettype none
module uvst_inverse_time #(
    parameter int W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] dial,
    input  wire logic [W-1:0] expo,
    input  wire logic [W-1:0] ratio,
    output logic      [31:0]  ticks
);
    // ************************************************
    // Delay = dial / (1 - ratio^a), a linearised as
    // 1 - r^a ~ a*(1-r); keeps the area small
    // ************************************************
    if (W < 8) $error("uvst_inverse_time: W too small");
    logic [31:0] deficit;
    logic [31:0] denom;
    logic [47:0] numer;
    always_comb begin
        deficit = (ratio >= W'(100)) ? 32'h0000_0000 : 32'(W'(100) - ratio);
        denom   = (32'(expo) * deficit) / 32'h0000_0064;
        if (denom == 32'h0000_0000) begin
            denom = 32'h0000_0001;
        end
        // Dial in 0.01 s, result in 5 ms ticks: x2 then /denom*100
        numer   = 48'(dial) * 48'h0000_0000_00C8;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ticks <= 32'h0000_0000;
        end else begin
            ticks <= 32'(numer / 48'(denom));
        end
    end
endmodule // uvst_inverse_time
`default_nettype wire

// ===== core/uvst_pkg.sv
// Types for the undervoltage stage timing block
package uvst_pkg;
    typedef enum logic [1:0] {
        UVST_FORCE_NORMAL,
        UVST_FORCE_START,
        UVST_FORCE_OPERATE,
        UVST_FORCE_INHIBITED
    } uvst_force_e;
    typedef enum logic {
        UVST_FIXED_DELAY_MODE,
        UVST_INVERSE_DELAY_MODE
    } uvst_dtype_e;
    typedef enum logic [1:0] {
        UVST_IDLE,
        UVST_TIMING,
        UVST_RELEASE,
        UVST_OPERATED
    } uvst_state_e;
endpackage : uvst_pkg

// ===== core/uvst_stage.sv
// Undervoltage stage decision and timing with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "uvst_defs.svh"
module uvst_stage #(
    parameter int TICK_CYCLES = `UVST_TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [15:0] ratio_a,
    input  wire logic [15:0] ratio_b,
    input  wire logic [15:0] ratio_c,
    input  wire logic        block_in,
    output logic             start_out,
    output logic             operate_out,
    output logic             inhibited_flag
);
    if (TICK_CYCLES < 2) $error("uvst_stage: TICK_CYCLES too small");
    // ************************************************
    // Bus slave
    // ************************************************
    logic [31:0] ctrl_reg, delay_reg, dial_reg, expo_reg, release_reg, blklvl_reg;
    logic        wr_pend_reg, deen_blk_reg;
    logic [11:0] addr_reg;
    logic [31:0] rd_mux;
    logic signed [31:0] remain_reg;
    logic [15:0] low_ratio;
    logic [31:0] expect_ticks;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg    <= 12'h000;
        end else begin
            wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                addr_reg <= haddr[11:0];
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg    <= `UVST_CTRL_RESET;
            delay_reg   <= `UVST_DELAY_RESET;
            dial_reg    <= `UVST_DIAL_RESET;
            expo_reg    <= `UVST_EXPO_RESET;
            release_reg <= `UVST_RELEASE_RESET;
            blklvl_reg  <= `UVST_BLKLVL_RESET;
        end else if (wr_pend_reg) begin
            case (addr_reg)
                `UVST_CTRL_OFS:    ctrl_reg    <= {25'h000_0000, hwdata[6:0]};
                `UVST_DELAY_OFS:   delay_reg   <= hwdata;
                `UVST_DIAL_OFS:    dial_reg    <= {16'h0000, hwdata[15:0]};
                `UVST_EXPO_OFS:    expo_reg    <= {16'h0000, hwdata[15:0]};
                `UVST_RELEASE_OFS: release_reg <= hwdata;
                `UVST_BLKLVL_OFS:  blklvl_reg  <= {16'h0000, hwdata[15:0]};
                default: ;
            endcase
        end
    end
    // ************************************************
    // Evaluation tick and sampled inputs
    // ************************************************
    logic [31:0] tick_cnt_reg;
    logic        tick, blk_s1_reg, blk_s2_reg, blk_smp_reg;
    assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_s1_reg  <= 1'b0;
            blk_s2_reg  <= 1'b0;
            blk_smp_reg <= 1'b0;
        end else begin
            blk_s1_reg <= block_in;
            blk_s2_reg <= blk_s1_reg;
            if (tick) begin
                blk_smp_reg <= blk_s2_reg;
            end
        end
    end
    // ************************************************
    // Pickup comparator, ratios
    // ************************************************
    logic        pickup_reg;
    logic [15:0] min_ab;
    assign min_ab    = (ratio_a < ratio_b) ? ratio_a : ratio_b;
    assign low_ratio = (min_ab < ratio_c) ? min_ab : ratio_c;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pickup_reg <= 1'b0;
        end else if (tick) begin
            if (low_ratio < `UVST_ONE_RATIO) begin
                pickup_reg <= 1'b1;
            end else if (ratio_a > `UVST_HYST_PCT && ratio_b > `UVST_HYST_PCT
                         && ratio_c > `UVST_HYST_PCT) begin
                pickup_reg <= 1'b0;
            end
        end
    end
    // Ratios are in units of 0.01 of the pickup setting; so is block level
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            deen_blk_reg <= 1'b0;
        end else if (tick) begin
            if (blklvl_reg[15:0] == 16'h0000) begin
                deen_blk_reg <= 1'b0;
            end else if (low_ratio < blklvl_reg[15:0]) begin
                deen_blk_reg <= 1'b1;
            end else if (low_ratio >= `UVST_ONE_RATIO) begin
                deen_blk_reg <= 1'b0;
            end
        end
    end
    // ************************************************
    // Operate-time calculation
    // ************************************************
    uvst_inverse_time #(.W(16)) u_inv (
        .hclk    (hclk),
        .hresetn (hresetn),
        .dial    (dial_reg[15:0]),
        .expo    (expo_reg[15:0]),
        .ratio   (low_ratio),
        .ticks   (expect_ticks)
    );
    logic        inv_mode;
    logic [31:0] target;
    assign inv_mode = ctrl_reg[`UVST_CTRL_INV_BIT];
    assign target   = inv_mode ? expect_ticks : delay_reg;
    // ************************************************
    // Stage state machine
    // ************************************************
    uvst_pkg::uvst_state_e state_reg;
    logic [31:0] op_cnt_reg, rel_cnt_reg;
    logic        start_reg, operate_reg, inhib_reg;
    logic        pk_ok, instant, expired;
    assign pk_ok   = pickup_reg && !blk_smp_reg;
    assign instant = !inv_mode && delay_reg == 32'h0000_0000;
    assign expired = op_cnt_reg + 32'h0000_0001 >= target;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= uvst_pkg::UVST_IDLE;
            op_cnt_reg  <= 32'h0000_0000;
            rel_cnt_reg <= 32'h0000_0000;
            start_reg   <= 1'b0;
            operate_reg <= 1'b0;
            inhib_reg   <= 1'b0;
        end else if (tick) begin
            inhib_reg <= pickup_reg && blk_smp_reg && !start_reg;
            case (state_reg)
                uvst_pkg::UVST_IDLE: begin
                    operate_reg <= 1'b0;
                    if (pk_ok && !deen_blk_reg) begin
                        start_reg <= 1'b1;
                        if (instant) begin
                            operate_reg <= 1'b1;
                            state_reg   <= uvst_pkg::UVST_OPERATED;
                        end else begin
                            state_reg <= uvst_pkg::UVST_TIMING;
                        end
                    end
                end
                uvst_pkg::UVST_TIMING: begin
                    if (!pk_ok) begin
                        rel_cnt_reg <= 32'h0000_0000;
                        if (!ctrl_reg[`UVST_CTRL_DREL_BIT] || release_reg == 32'h0000_0000) begin
                            start_reg <= 1'b0;
                        end
                        if (!ctrl_reg[`UVST_CTRL_TRST_BIT]) begin
                            op_cnt_reg <= 32'h0000_0000;
                        end
                        state_reg <= (release_reg == 32'h0000_0000) ? uvst_pkg::UVST_IDLE
                                                                    : uvst_pkg::UVST_RELEASE;
                    end else if (expired && !deen_blk_reg) begin
                        operate_reg <= 1'b1;
                        state_reg   <= uvst_pkg::UVST_OPERATED;
                    end else begin
                        op_cnt_reg <= op_cnt_reg + 32'h0000_0001;
                    end
                end
                uvst_pkg::UVST_RELEASE: begin
                    if (pk_ok) begin
                        start_reg   <= 1'b1;
                        operate_reg <= instant && !deen_blk_reg;
                        state_reg   <= (instant && !deen_blk_reg) ? uvst_pkg::UVST_OPERATED : uvst_pkg::UVST_TIMING;
                    end else if (rel_cnt_reg + 32'h0000_0001 >= release_reg) begin
                        start_reg  <= 1'b0;
                        op_cnt_reg <= 32'h0000_0000;
                        state_reg  <= uvst_pkg::UVST_IDLE;
                    end else begin
                        rel_cnt_reg <= rel_cnt_reg + 32'h0000_0001;
                        if (ctrl_reg[`UVST_CTRL_CONT_BIT]) begin
                            if (expired && !deen_blk_reg && start_reg) begin
                                operate_reg <= 1'b1;
                                state_reg   <= uvst_pkg::UVST_OPERATED;
                            end else begin
                                op_cnt_reg <= op_cnt_reg + 32'h0000_0001;
                            end
                        end
                    end
                end
                uvst_pkg::UVST_OPERATED: begin
                    if (!pk_ok) begin
                        start_reg   <= 1'b0;
                        operate_reg <= 1'b0;
                        op_cnt_reg  <= 32'h0000_0000;
                        state_reg   <= uvst_pkg::UVST_IDLE;
                    end
                end
                default: state_reg <= uvst_pkg::UVST_IDLE;
            endcase
        end
    end
    // Remaining time, signed in 5 ms ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain_reg <= 32'sh0000_0000;
        end else begin
            remain_reg <= $signed(target) - $signed(op_cnt_reg);
        end
    end
    // ************************************************
    // Forced outputs
    // ************************************************
    uvst_pkg::uvst_force_e fsel;
    assign fsel = uvst_pkg::uvst_force_e'(ctrl_reg[`UVST_CTRL_FSEL_LSB +: 2]);
    always_comb begin
        start_out      = start_reg;
        operate_out    = operate_reg;
        inhibited_flag = inhib_reg;
        if (ctrl_reg[`UVST_CTRL_FEN_BIT]) begin
            start_out      = fsel == uvst_pkg::UVST_FORCE_START;
            operate_out    = fsel == uvst_pkg::UVST_FORCE_OPERATE;
            inhibited_flag = fsel == uvst_pkg::UVST_FORCE_INHIBITED;
        end
    end
    // ************************************************
    // Read mux
    // ************************************************
    always_comb begin
        case (addr_reg)
            `UVST_CTRL_OFS:     rd_mux = ctrl_reg;
            `UVST_DELAY_OFS:    rd_mux = delay_reg;
            `UVST_DIAL_OFS:     rd_mux = dial_reg;
            `UVST_EXPO_OFS:     rd_mux = expo_reg;
            `UVST_RELEASE_OFS:  rd_mux = release_reg;
            `UVST_BLKLVL_OFS:   rd_mux = blklvl_reg;
            `UVST_STATUS_OFS:   rd_mux = {26'h000_0000, deen_blk_reg, pickup_reg, blk_smp_reg,
                                          inhibited_flag, operate_out, start_out};
            `UVST_REMAIN_OFS:   rd_mux = remain_reg;
            `UVST_RATIO_AB_OFS: rd_mux = {ratio_b, ratio_a};
            `UVST_RATIO_C_OFS:  rd_mux = {low_ratio, ratio_c};
            `UVST_EXPECT_OFS:   rd_mux = target;
            default:            rd_mux = 32'h0000_0000;
        endcase
        hrdata = rd_mux;
    end
    // ************************************************
    // Checks
    // ************************************************
    property p_inhibit_no_start;
        @(posedge hclk) disable iff (!hresetn)
        (tick && state_reg == uvst_pkg::UVST_IDLE && pickup_reg && blk_smp_reg) |=> !start_reg && inhib_reg;
    endproperty
    a_inhibit_no_start: assert property (p_inhibit_no_start) else $error("inhibit failed");
    property p_start;
        @(posedge hclk) disable iff (!hresetn)
        (tick && state_reg == uvst_pkg::UVST_IDLE && pk_ok && !deen_blk_reg) |=> start_reg;
    endproperty
    a_start: assert property (p_start) else $error("start missing");
    property p_instant;
        @(posedge hclk) disable iff (!hresetn)
        (tick && pk_ok && !deen_blk_reg && instant
         && (state_reg == uvst_pkg::UVST_IDLE || state_reg == uvst_pkg::UVST_RELEASE)) |=> operate_reg;
    endproperty
    a_instant: assert property (p_instant) else $error("instant operate late");
    property p_tick_period;
        @(posedge hclk) disable iff (!hresetn) tick |=> !tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick too fast");
    property p_state_on_tick;
        @(posedge hclk) disable iff (!hresetn) !tick |=> $stable(state_reg);
    endproperty
    a_state_on_tick: assert property (p_state_on_tick) else $error("state moved off tick");
    property p_deen;
        @(posedge hclk) disable iff (!hresetn) tick && blklvl_reg[15:0] == 16'h0000 |=> !deen_blk_reg;
    endproperty
    a_deen: assert property (p_deen) else $error("zero level still blocks");
    property p_no_rel_drop;
        @(posedge hclk) disable iff (!hresetn)
        (tick && state_reg == uvst_pkg::UVST_TIMING && !pk_ok && ctrl_reg[1] && release_reg != 0) |=> start_reg;
    endproperty
    a_no_rel_drop: assert property (p_no_rel_drop) else $error("start dropped early");
    property p_force;
        @(posedge hclk) disable iff (!hresetn)
        ctrl_reg[`UVST_CTRL_FEN_BIT] && fsel == uvst_pkg::UVST_FORCE_OPERATE |-> operate_out && !start_out;
    endproperty
    a_force: assert property (p_force) else $error("force not applied");
endmodule // uvst_stage
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench for the undervoltage stage
`timescale 1ns/1ps
`default_nettype none
`include "uvst_defs.svh"
module tb_top;
    localparam int TK = 10;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, block_req, block_in;
    logic        start_out, operate_out, inhibited_flag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] lvl_a, lvl_b, lvl_c, ratio_a, ratio_b, ratio_c;
    int          fails, samples_checked, n, f;

    uvst_stage #(.TICK_CYCLES(TK)) uvst_stage_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ratio_a(ratio_a), .ratio_b(ratio_b), .ratio_c(ratio_c),
        .block_in(block_in), .start_out(start_out), .operate_out(operate_out), .inhibited_flag(inhibited_flag));
    uvst_front_model uvst_front_model_i (.hclk(hclk), .hresetn(hresetn), .lvl_a(lvl_a), .lvl_b(lvl_b),
        .lvl_c(lvl_c), .block_req(block_req), .ratio_a(ratio_a), .ratio_b(ratio_b), .ratio_c(ratio_c),
        .block_in(block_in));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // ***************************************
    // Shared tasks
    // ***************************************
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Waits on ready are bounded; no wait-state count is assumed
    task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
        int i;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, ofs};
        htrans <= 2'b10;
        hwrite <= wr;
        for (int ph = 0; ph < 2; ph++) begin
            i = 0;
            do begin
                @(posedge hclk);
                i++;
            end while (hreadyout !== 1'b1 && i < 50);
            if (i >= 50) begin
                fails++;
                final_report;
            end
            if (ph == 0) begin
                htrans <= 2'b00;
                hwdata <= wd;
            end
        end
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [11:0] ofs, input logic [31:0] exp, input string what);
        ahb(1'b0, ofs, 32'h0000_0000);
        check(what, rd, exp);
    endtask

    task automatic lv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic blk);
        @(posedge hclk);
        lvl_a     <= a;
        lvl_b     <= b;
        lvl_c     <= c;
        block_req <= blk;
    endtask

    task automatic ticks(input int k);
        repeat (k * TK) @(posedge hclk);
    endtask

    // Which: 0 start, 1 operate, 2 inhibited; counts clocks waited
    task automatic wait_out(input int which, input logic val, input int lim, output int cyc);
        cyc = 0;
        while ((which == 0 ? start_out : which == 1 ? operate_out : inhibited_flag) !== val) begin
            @(posedge hclk);
            #1;
            cyc++;
            if (cyc > lim * TK) begin
                $display("unexpected wait on output %0d expected %b", which, val);
                fails++;
                final_report;
            end
        end
    endtask

    // ***************************************
    // Main sequence
    // ***************************************
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
        lvl_a = 16'h006E; lvl_b = 16'h006E; lvl_c = 16'h006E; block_req = 1'b0; fails = 0; samples_checked = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`UVST_CTRL_OFS, `UVST_CTRL_RESET, "ctrl reset");
        rdchk(`UVST_DELAY_OFS, `UVST_DELAY_RESET, "delay reset");
        rdchk(`UVST_DIAL_OFS, `UVST_DIAL_RESET, "dial reset");
        rdchk(`UVST_EXPO_OFS, `UVST_EXPO_RESET, "exponent reset");
        rdchk(`UVST_RELEASE_OFS, `UVST_RELEASE_RESET, "release reset");
        rdchk(`UVST_BLKLVL_OFS, `UVST_BLKLVL_RESET, "block level reset");
        rdchk(12'h040, 32'h0000_0000, "unmapped read");
        check("hresp okay", 32'(hresp), 32'h0000_0000);
        $display("test reset values done");

        ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_0000);
        ahb(1'b1, `UVST_DELAY_OFS, 32'h0000_0006);
        lv(16'h0050, 16'h005F, 16'h0064, 1'b0);
        wait_out(0, 1'b1, 3, n);
        rdchk(`UVST_RATIO_AB_OFS, 32'h005F_0050, "ratio ab");
        rdchk(`UVST_RATIO_C_OFS, 32'h0050_0064, "ratio c lowest");
        ahb(1'b0, `UVST_REMAIN_OFS, 32'h0000_0000);
        check("remain in range", 32'($signed(rd) > 0 && $signed(rd) <= 6), 32'h0000_0001);
        wait_out(1, 1'b1, 8, n);
        check("fixed delay window", 32'(n >= 3 * TK && n <= 7 * TK), 32'h0000_0001);
        lv(16'h0066, 16'h0066, 16'h0066, 1'b0);
        ticks(3);
        check("start held in hysteresis", 32'(start_out), 32'h0000_0001);
        lv(16'h0068, 16'h0068, 16'h0068, 1'b0);
        wait_out(0, 1'b0, 3, n);
        $display("test fixed delay done");

        ahb(1'b1, `UVST_DELAY_OFS, 32'h0000_0000);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b0);
        wait_out(0, 1'b1, 3, n);
        check("instant operate", 32'(operate_out), 32'h0000_0001);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        wait_out(0, 1'b0, 3, n);
        $display("test instant done");

        ahb(1'b1, `UVST_DELAY_OFS, 32'h0000_0028);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b0);
        wait_out(0, 1'b1, 3, n);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b1);
        wait_out(0, 1'b0, 4, n);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b1);
        ticks(3);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b1);
        wait_out(2, 1'b1, 4, n);
        ticks(10);
        check("start while blocked", 32'(start_out), 32'h0000_0000);
        check("operate while blocked", 32'(operate_out), 32'h0000_0000);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        ticks(3);
        $display("test blocking done");

        ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_0006);
        ahb(1'b1, `UVST_RELEASE_OFS, 32'h0000_0004);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b0);
        wait_out(0, 1'b1, 3, n);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        ticks(2);
        check("start held in release", 32'(start_out), 32'h0000_0001);
        wait_out(0, 1'b0, 5, n);
        $display("test release done");

        // Expected ticks k*20000/(a*(100-r)) from the linear approximation
        ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_0001);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b0);
        wait_out(0, 1'b1, 3, n);
        ahb(1'b0, `UVST_EXPECT_OFS, 32'h0000_0000);
        check("inverse time 0.80", 32'(rd >= 49 && rd <= 51), 32'h0000_0001);
        lv(16'h0032, 16'h0032, 16'h0032, 1'b0);
        ticks(2);
        ahb(1'b0, `UVST_EXPECT_OFS, 32'h0000_0000);
        check("inverse time 0.50", 32'(rd >= 19 && rd <= 21), 32'h0000_0001);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        wait_out(0, 1'b0, 3, n);
        $display("test inverse done");

        ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_0000);
        ahb(1'b1, `UVST_DELAY_OFS, 32'h0000_0002);
        lv(16'h0005, 16'h0005, 16'h0005, 1'b0);
        ticks(8);
        check("operate when de-energised", 32'(operate_out), 32'h0000_0000);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        ticks(3);
        ahb(1'b1, `UVST_BLKLVL_OFS, 32'h0000_0000);
        lv(16'h0005, 16'h0005, 16'h0005, 1'b0);
        wait_out(1, 1'b1, 6, n);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        wait_out(0, 1'b0, 3, n);
        $display("test de-energised done");

        ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_000E);
        ahb(1'b1, `UVST_DELAY_OFS, 32'h0000_0006);
        ahb(1'b1, `UVST_RELEASE_OFS, 32'h0000_0014);
        lv(16'h0050, 16'h0050, 16'h0050, 1'b0);
        wait_out(0, 1'b1, 3, n);
        lv(16'h006E, 16'h006E, 16'h006E, 1'b0);
        wait_out(1, 1'b1, 10, n);
        check("start held until operate", 32'(start_out), 32'h0000_0001);
        wait_out(0, 1'b0, 3, n);
        $display("test continue in release done");

        for (f = 0; f < 4; f++) begin
            ahb(1'b1, `UVST_CTRL_OFS, 32'h0000_0010 | (f << 5));
            @(negedge hclk);
            check("forced start", 32'(start_out), 32'(f == 1));
            check("forced operate", 32'(operate_out), 32'(f == 2));
            check("forced inhibited", 32'(inhibited_flag), 32'(f == 3));
        end
        $display("test forcing done");

        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        check("start in reset", 32'(start_out), 32'h0000_0000);
        check("operate in reset", 32'(operate_out), 32'h0000_0000);
        check("inhibited in reset", 32'(inhibited_flag), 32'h0000_0000);
        @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`UVST_CTRL_OFS, `UVST_CTRL_RESET, "ctrl after reset");
        $display("test mid-run reset done");
        final_report;
    end
endmodule // tb_top
`default_nettype wire

// ===== tb/uvst_front_model.sv
// Model of the voltage front end and the blocking matrix
`timescale 1ns/1ps
`default_nettype none
module uvst_front_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [15:0] lvl_a,
    input  wire logic [15:0] lvl_b,
    input  wire logic [15:0] lvl_c,
    input  wire logic        block_req,
    output logic      [15:0] ratio_a,
    output logic      [15:0] ratio_b,
    output logic      [15:0] ratio_c,
    output logic             block_in
);
    // ***************************************
    // Registered outputs, one clock of latency
    // ***************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ratio_a  <= 16'h006E;
            ratio_b  <= 16'h006E;
            ratio_c  <= 16'h006E;
            block_in <= 1'b0;
        end else begin
            ratio_a  <= lvl_a;
            ratio_b  <= lvl_b;
            ratio_c  <= lvl_c;
            // Bench raises block long before any expiry
            block_in <= block_req;
        end
    end
endmodule // uvst_front_model
`default_nettype wire
